// >>> dv/nsc_mem_model.sv
// nsc_mem_model.sv: program memory answering scanner fetches
`default_nettype none
module nsc_mem_model #(
  parameter logic [15:0] PAT = 16'h5A3C
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [3:0] i_lat,
  output logic o_valid,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // data flips every clock outside the valid cycle, so stale reads show
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_data <= 16'h0000;
      wait_cnt <= 4'h0;
    end else begin
      o_valid <= 1'b0;
      o_data <= ~o_data;
      if (i_rd && !o_valid) begin
        if (wait_cnt >= i_lat) begin
          o_valid <= 1'b1;
          o_data <= i_addr ^ PAT;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // nsc_mem_model
`default_nettype wire

// >>> dv/nsc_scanner_properties.sv
// nsc_scanner_properties.sv: port checks for the scanner
`default_nettype none
module nsc_scanner_properties #(
  parameter logic [15:0] MEM_WORDS = 16'h4000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic i_mem_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----
  // fetch side
  // ----
  a_addr_advance: assert property (o_mem_rd && i_mem_valid
    |=> o_mem_addr == $past(o_mem_addr) + 16'h0001)
    else $error("fetch address did not advance");
  a_addr_stable: assert property (o_mem_rd && !i_mem_valid
    |=> o_mem_addr == $past(o_mem_addr))
    else $error("fetch address moved while waiting");
  // crc needs its shifting time before it asks again
  a_fetch_gap: assert property (o_mem_rd && i_mem_valid
    |=> !o_mem_rd [*8])
    else $error("fetch started while crc busy");
  a_fetch_range: assert property (o_mem_rd
    |-> o_mem_addr < MEM_WORDS)
    else $error("fetch beyond program memory");
  // ----
  // register bus
  // ----
  // the slave may take a new address while answering, so check the answer
  a_bresp_hold: assert property (o_bvalid && !i_bready
    |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before bready");
  a_bresp_code: assert property (o_bvalid |-> o_bresp inside {2'b00, 2'b10})
    else $error("illegal write response");
  a_read_ready: assert property (o_arready == !o_rvalid)
    else $error("read ready wrong");
  a_read_once: assert property (o_rvalid && i_rready |=>
    !o_rvalid ##0 o_rdata[31:8] == 24'h00_0000 || !o_rvalid)
    else $error("read answer repeated");
endmodule // nsc_scanner_properties

bind nsc_scanner nsc_scanner_properties #(.MEM_WORDS(MEM_WORDS)) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .o_awready(o_awready),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .i_bready(i_bready),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
  .i_mem_valid(i_mem_valid));
`default_nettype wire

// >>> dv/test_nsc_scanner.sv
// test_nsc_scanner.sv: self-checking bench for the scanner
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_nsc_scanner;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a, w, x; logic [1:0] r;} nsc_row_t;
  localparam logic [15:0] PAT = 16'h5A3C;
  logic i_clk = 0, i_resetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, rv, v0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic irq = 0, idle = 1;
  logic [3:0] lat = 0, tcnt = 0;
  logic [1:0] br, rr;
  logic [15:0] crc = 16'h0000;
  wire logic awready, wready, bvalid, arready, rvalid, mrd, mvalid, stall;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] maddr, mdata;
  int errors = 0, num_checks = 0, fetches = 0, nf, n0, fs, stalls = 0, ss;
  nsc_row_t rows [10] = '{
    '{8'h08, 8'hA5, 8'hA5, 2'h0}, '{8'h0C, 8'h00, 8'h01, 2'h0},
    '{8'h0C, 8'hFE, 8'hFF, 2'h0}, '{8'h00, 8'hFF, 8'h00, 2'h0},
    '{8'h04, 8'hFF, 8'h00, 2'h0}, '{8'h14, 8'h12, 8'h12, 2'h0},
    '{8'h20, 8'h78, 8'h78, 2'h0}, '{8'h24, 8'hFF, 8'h0F, 2'h0},
    '{8'h28, 8'h8F, 8'h8F, 2'h0}, '{8'h30, 8'hAA, 8'h00, 2'h2}};

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    tcnt <= tcnt + 4'h1;
    if (mrd && mvalid) fetches <= fetches + 1;
    if (stall) stalls <= stalls + 1;
  end

  nsc_scanner DUT (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_mem_rd(mrd), .o_mem_addr(maddr), .i_mem_valid(mvalid),
    .i_mem_rdata(mdata), .i_irq_active(irq), .i_cpu_mem_idle(idle),
    .i_trig_src({10{tcnt[3]}}), .o_cpu_stall(stall));
  nsc_mem_model #(.PAT(PAT)) MEM (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_rd(mrd), .i_addr(maddr), .i_lat(lat), .o_valid(mvalid),
    .o_data(mdata));

  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit da, dw, b;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    da = 0;
    dw = 0;
    do begin
      @(negedge i_clk);
      da = da | awready;
      dw = dw | wready;
      b = bvalid;
      br = bresp;
      @(posedge i_clk);
      if (da) awvalid <= 0;
      if (dw) wvalid <= 0;
    end while (!b);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    bit da, b;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    da = 0;
    do begin
      @(negedge i_clk);
      da = da | arready;
      b = rvalid;
      rv = rdata[7:0];
      rr = rresp;
      @(posedge i_clk);
      if (da) arvalid <= 0;
    end while (!b);
    rready <= 0;
  endtask

  function automatic logic [15:0] crcw(logic [15:0] s, d, t);
    for (int i = 15; i >= 0; i--)
      s = {s[14:0], 1'b0} ^ ((s[15] ^ d[i]) ? t : 16'h0000);
    return s;
  endfunction

  // address pairs are loaded while run is low, then written again with run set to check the guard
  task automatic scan(input logic [7:0] c, input logic [15:0] lo, hi,
                      input bit w);
    wr(8'h14, lo[15:8]);
    wr(8'h18, lo[7:0]);
    wr(8'h1C, hi[15:8]);
    wr(8'h20, hi[7:0]);
    ss = stalls;
    fs = fetches;
    wr(8'h10, c);
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'hFF);
    if (w) begin
      do rd(8'h10); while (rv[6]);
      nf = fetches - fs;
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1;
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4));
      `CHK("reset", (i == 3) ? 8'h01 : 8'h00, rv)
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK("bresp", rows[i].r, br)
      `CHK("rdata", rows[i].x, rv)
      `CHK("rresp", rows[i].r, rr)
    end
    wr(8'h24, 8'h00);
    wr(8'h08, 8'h10);
    wr(8'h0C, 8'h21);
    // every mode with an interrupt standing, suspend off except in peek
    for (int m = 0; m < 4; m++) begin
      irq <= 1;
      lat <= 4'(m * 2);
      scan(8'hC0 | 8'(m) | (m == 2 ? 8'h08 : 8'h00), 16'h0010, 16'h0012, 1);
      `CHK("fetches", 3, nf)
      `CHK("stall", m != 2, stalls != ss)
      rd(8'h18);
      `CHK("cur", 8'h13, rv)
      rd(8'h1C);
      `CHK("end", 8'h00, rv)
      if (m == 0) begin
        for (int k = 16; k < 19; k++) crc = crcw(crc, 16'(k) ^ PAT, 16'h1021);
        repeat (40) @(posedge i_clk);
        rd(8'h00);
        `CHK("shift hi", crc[15:8], rv)
        rd(8'h04);
        `CHK("shift lo", crc[7:0], rv)
      end
    end
    // suspend holds the scan off until the interrupt ends
    irq <= 1;
    n0 = fetches;
    fork
      begin
        repeat (60) @(posedge i_clk);
        n0 = fetches - n0;
        irq <= 0;
      end
    join_none
    scan(8'hC8, 16'h0030, 16'h0031, 1);
    `CHK("held", 0, n0)
    `CHK("resume", 2, nf)
    scan(8'hC0, 16'h3FFF, 16'h3FFF, 1);
    rd(8'h10);
    `CHK("invalid", 1'b1, rv[4])
    rd(8'h14);
    `CHK("cur hi", 8'h40, rv)
    // a reserved trigger select never starts a transfer; disabling first
    // drops any trigger still pending from the earlier scans
    wr(8'h24, 8'h0A);
    wr(8'h10, 8'h03);
    scan(8'hC3, 16'h0040, 16'h0040, 0);
    repeat (60) @(posedge i_clk);
    `CHK("reserved trig", fs, fetches)
    wr(8'h10, 8'h83);
    // switch off in mid-burst; run is left set so only the enable stops it
    lat <= 3;
    scan(8'hC1, 16'h0000, 16'h00FF, 0);
    repeat (60) @(posedge i_clk);
    wr(8'h10, 8'h41);
    rd(8'h18);
    v0 = rv;
    fs = fetches;
    repeat (60) @(posedge i_clk);
    `CHK("stopped", fs, fetches)
    `CHK("no stall", 1'b0, stall)
    rd(8'h18);
    `CHK("cur kept", v0, rv)
    rd(8'h20);
    `CHK("end kept", 8'hFF, rv)
    rd(8'h10);
    `CHK("ctrl", 8'h41, rv)
    results();
  end
endmodule // test_nsc_scanner
`default_nettype wire

// >>> rtl/nsc_crc_shifter.v
// nsc_crc_shifter.v: serial crc shifter fed one word at a time
`default_nettype none

module nsc_crc_shifter (
  input wire i_clk,
  input wire i_resetn,
  input wire i_enable,
  input wire i_load,
  input wire [15:0] i_data,
  input wire [15:0] i_taps,
  input wire [3:0] i_poly_len,
  output wire o_ready,
  output wire [15:0] o_shift
);

`include "nsc_defines.vh"

reg [15:0] shift_reg;
reg [15:0] data_reg;
reg [4:0] count_reg;
wire [15:0] mask;
wire feedback;

// ----------------------------------------------------------------
// only bits up to the polynomial length take part
// ----------------------------------------------------------------
genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1) begin : g_mask
    assign mask[gi] = (gi <= i_poly_len);
  end
endgenerate

assign feedback = shift_reg[i_poly_len] ^ data_reg[15];
assign o_ready = i_enable && (count_reg == 5'h00);
assign o_shift = shift_reg;

always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    shift_reg <= 16'h0000;
    data_reg <= 16'h0000;
    count_reg <= 5'h00;
  end else if (!i_enable) begin
    shift_reg <= 16'h0000;
    data_reg <= 16'h0000;
    count_reg <= 5'h00;
  end else if (count_reg != 5'h00) begin
    // each set tap xors the feedback into its term
    shift_reg <= ({shift_reg[14:0], 1'b0} ^
                  ({16{feedback}} & i_taps)) & mask;
    data_reg <= {data_reg[14:0], 1'b0};
    count_reg <= count_reg - 5'h01;
  end else if (i_load) begin
    data_reg <= i_data;
    count_reg <= `NSC_WORD_BITS;
  end
end

endmodule // nsc_crc_shifter

`default_nettype wire

// >>> rtl/nsc_defines.vh
// nsc_defines.vh: offsets, fields, reset values and codes of the scanner
`ifndef NSC_DEFINES_VH
`define NSC_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define NSC_OFF_SHIFT_HIGH 8'h00
`define NSC_OFF_SHIFT_LOW 8'h04
`define NSC_OFF_TAPS_HIGH 8'h08
`define NSC_OFF_TAPS_LOW 8'h0C
`define NSC_OFF_SCAN_CTRL 8'h10
`define NSC_OFF_CUR_HIGH 8'h14
`define NSC_OFF_CUR_LOW 8'h18
`define NSC_OFF_END_HIGH 8'h1C
`define NSC_OFF_END_LOW 8'h20
`define NSC_OFF_TRIG_SEL 8'h24
`define NSC_OFF_CRC_CFG 8'h28

// ----------------------------------------------------------------
// scanner control and crc config fields
// ----------------------------------------------------------------
`define NSC_CTRL_EN 7
`define NSC_CTRL_RUN 6
`define NSC_CTRL_BUSY 5
`define NSC_CTRL_INVALID 4
`define NSC_CTRL_IRQ_SUSP 3
`define NSC_CRC_CFG_EN 7

// ----------------------------------------------------------------
// access modes, reset values, trigger codes, memory and word sizes
// ----------------------------------------------------------------
`define NSC_MODE_CONCURRENT 2'h0
`define NSC_MODE_BURST 2'h1
`define NSC_MODE_PEEK 2'h2
`define NSC_MODE_TRIGGERED 2'h3
`define NSC_RST_BYTE 8'h00
`define NSC_RST_TAPS 16'h0001
`define NSC_RST_ADDR 16'h0000
`define NSC_TRIG_LAST 4'h9
`define NSC_MEM_WORDS 16'h4000
`define NSC_WORD_BITS 5'h10

`endif

// >>> rtl/nsc_scanner.v
// nsc_scanner.v: program memory scanner with crc register file on axi4-lite
`default_nettype none

`include "nsc_defines.vh"

module nsc_scanner #(
  parameter [15:0] MEM_WORDS = `NSC_MEM_WORDS,
  parameter integer TRIG_COUNT = 10
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output wire o_mem_rd,
  output wire [15:0] o_mem_addr,
  input wire i_mem_valid,
  input wire [15:0] i_mem_rdata,
  input wire i_irq_active,
  input wire i_cpu_mem_idle,
  input wire [TRIG_COUNT-1:0] i_trig_src,
  output wire o_cpu_stall
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_READ = 2'h1;
localparam [1:0] ST_FEED = 2'h2;

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
reg [15:0] taps_reg;
reg scan_en_reg;
reg scan_run_reg;
reg irq_suspend_mode_reg;
reg [1:0] access_mode_bits_reg;
reg [15:0] scan_current_addr_reg;
reg [15:0] scan_end_addr_reg;
reg [3:0] trigger_select_reg;
reg crc_en_reg;
reg [3:0] poly_length_reg;

// ----------------------------------------------------------------
// scanner state
// ----------------------------------------------------------------
reg [1:0] state_reg;
reg [15:0] word_reg;
reg trig_pend_reg;
reg trig_prev_reg;
reg [TRIG_COUNT-1:0] trig_meta_reg;
reg [TRIG_COUNT-1:0] trig_sync_reg;

// ----------------------------------------------------------------
// bus slave state
// ----------------------------------------------------------------
reg aw_full_reg;
reg [7:0] aw_addr_reg;
reg w_full_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;

wire crc_ready;
wire [15:0] crc_shift;
wire run_eff;
wire past_end;
wire invalid;
wire busy;
wire trig_level;
wire trig_edge;
wire mode_ok;
wire start;
wire wr_fire;
wire wr_byte;
wire addr_wr_ok;
reg wr_hit;
reg rd_hit;
reg [7:0] rd_byte;
reg mode_ok_c;

// ----------------------------------------------------------------
// scan condition
// ----------------------------------------------------------------
// peek ignores the suspend option; other modes drop run during interrupts
assign run_eff = scan_run_reg &&
                 !(irq_suspend_mode_reg && i_irq_active &&
                   access_mode_bits_reg != `NSC_MODE_PEEK);
assign past_end = scan_current_addr_reg > scan_end_addr_reg;
assign invalid = scan_current_addr_reg >= MEM_WORDS;
assign busy = scan_en_reg &&
              ((state_reg != ST_IDLE) || (run_eff && crc_ready));

// reserved selects give no trigger at all
assign trig_level = (trigger_select_reg <= `NSC_TRIG_LAST) &&
                    (trigger_select_reg < TRIG_COUNT) &&
                    trig_sync_reg[trigger_select_reg];
assign trig_edge = trig_level && !trig_prev_reg;

always @* begin
  case (access_mode_bits_reg)
    `NSC_MODE_TRIGGERED: mode_ok_c = trig_pend_reg;
    `NSC_MODE_PEEK: mode_ok_c = i_cpu_mem_idle;
    default: mode_ok_c = 1'b1;
  endcase
end
assign mode_ok = mode_ok_c;

assign start = scan_en_reg && run_eff && crc_ready && !past_end &&
               !invalid && mode_ok && state_reg == ST_IDLE;

// burst holds the cpu for the whole range, peek never, others only per access
assign o_cpu_stall = scan_en_reg && access_mode_bits_reg != `NSC_MODE_PEEK &&
                     ((access_mode_bits_reg == `NSC_MODE_BURST &&
                       run_eff && !past_end && !invalid) ||
                      state_reg != ST_IDLE);
assign o_mem_rd = (state_reg == ST_READ);
assign o_mem_addr = scan_current_addr_reg;

// ----------------------------------------------------------------
// trigger synchroniser and scan fsm
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    trig_meta_reg <= {TRIG_COUNT{1'b0}};
    trig_sync_reg <= {TRIG_COUNT{1'b0}};
  end else begin
    trig_meta_reg <= i_trig_src;
    trig_sync_reg <= trig_meta_reg;
  end
end

always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    state_reg <= ST_IDLE;
    word_reg <= 16'h0000;
    trig_pend_reg <= 1'b0;
    trig_prev_reg <= 1'b0;
  end else if (!scan_en_reg) begin
    state_reg <= ST_IDLE;
    word_reg <= 16'h0000;
    trig_pend_reg <= 1'b0;
    trig_prev_reg <= 1'b0;
  end else begin
    trig_prev_reg <= trig_level;
    if (trig_edge) begin
      trig_pend_reg <= 1'b1;
    end else if (start) begin
      trig_pend_reg <= 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_reg <= ST_READ;
        end
      end
      ST_READ: begin
        if (i_mem_valid) begin
          word_reg <= i_mem_rdata;
          state_reg <= ST_FEED;
        end
      end
      ST_FEED: begin
        state_reg <= ST_IDLE;
      end
      default: begin
        state_reg <= ST_IDLE;
      end
    endcase
  end
end

nsc_crc_shifter u_shifter (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_enable(crc_en_reg),
  .i_load(state_reg == ST_FEED),
  .i_data(word_reg),
  .i_taps(taps_reg),
  .i_poly_len(poly_length_reg),
  .o_ready(crc_ready),
  .o_shift(crc_shift)
);

// ----------------------------------------------------------------
// axi4-lite write path
// ----------------------------------------------------------------
assign o_awready = !aw_full_reg;
assign o_wready = !w_full_reg;
assign wr_fire = aw_full_reg && w_full_reg && !o_bvalid;
assign wr_byte = wr_fire && w_strb_reg[0];
// address pair bytes are guarded while a scan may be running
assign addr_wr_ok = wr_byte && !scan_run_reg;

always @* begin
  case (aw_addr_reg)
    `NSC_OFF_SHIFT_HIGH, `NSC_OFF_SHIFT_LOW, `NSC_OFF_TAPS_HIGH,
    `NSC_OFF_TAPS_LOW, `NSC_OFF_SCAN_CTRL, `NSC_OFF_CUR_HIGH,
    `NSC_OFF_CUR_LOW, `NSC_OFF_END_HIGH, `NSC_OFF_END_LOW,
    `NSC_OFF_TRIG_SEL, `NSC_OFF_CRC_CFG: wr_hit = 1'b1;
    default: wr_hit = 1'b0;
  endcase
end

always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    aw_full_reg <= 1'b0;
    aw_addr_reg <= 8'h00;
    w_full_reg <= 1'b0;
    w_data_reg <= 32'h0000_0000;
    w_strb_reg <= 4'h0;
    o_bvalid <= 1'b0;
    o_bresp <= 2'h0;
  end else begin
    if (i_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {i_awaddr[7:2], 2'h0};
    end
    if (i_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end
    if (wr_fire) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      o_bvalid <= 1'b1;
      o_bresp <= wr_hit ? 2'h0 : 2'h2;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end
end

// ----------------------------------------------------------------
// register updates
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    taps_reg <= `NSC_RST_TAPS;
    scan_en_reg <= 1'b0;
    scan_run_reg <= 1'b0;
    irq_suspend_mode_reg <= 1'b0;
    access_mode_bits_reg <= `NSC_MODE_CONCURRENT;
    scan_current_addr_reg <= `NSC_RST_ADDR;
    scan_end_addr_reg <= `NSC_RST_ADDR;
    trigger_select_reg <= 4'h0;
    crc_en_reg <= 1'b0;
    poly_length_reg <= 4'h0;
  end else begin
    if (wr_byte) begin
      case (aw_addr_reg)
        `NSC_OFF_TAPS_HIGH: taps_reg[15:8] <= w_data_reg[7:0];
        // bit 0 is not stored, it stays one
        `NSC_OFF_TAPS_LOW: taps_reg[7:1] <= w_data_reg[7:1];
        `NSC_OFF_SCAN_CTRL: begin
          scan_en_reg <= w_data_reg[`NSC_CTRL_EN];
          scan_run_reg <= w_data_reg[`NSC_CTRL_RUN];
          irq_suspend_mode_reg <= w_data_reg[`NSC_CTRL_IRQ_SUSP];
          access_mode_bits_reg <= w_data_reg[1:0];
        end
        `NSC_OFF_TRIG_SEL: trigger_select_reg <= w_data_reg[3:0];
        `NSC_OFF_CRC_CFG: begin
          crc_en_reg <= w_data_reg[`NSC_CRC_CFG_EN];
          poly_length_reg <= w_data_reg[3:0];
        end
        default: begin
        end
      endcase
    end
    // disabling only resets the fsm; fields keep their value
    if (scan_en_reg && state_reg == ST_IDLE && past_end &&
        !(wr_byte && aw_addr_reg == `NSC_OFF_SCAN_CTRL)) begin
      scan_run_reg <= 1'b0;
    end
    if (addr_wr_ok && aw_addr_reg == `NSC_OFF_CUR_HIGH) begin
      scan_current_addr_reg[15:8] <= w_data_reg[7:0];
    end else if (addr_wr_ok && aw_addr_reg == `NSC_OFF_CUR_LOW) begin
      scan_current_addr_reg[7:0] <= w_data_reg[7:0];
    end else if (scan_en_reg && state_reg == ST_READ && i_mem_valid) begin
      scan_current_addr_reg <= scan_current_addr_reg + 16'h0001;
    end
    if (addr_wr_ok && aw_addr_reg == `NSC_OFF_END_HIGH) begin
      scan_end_addr_reg[15:8] <= w_data_reg[7:0];
    end else if (addr_wr_ok && aw_addr_reg == `NSC_OFF_END_LOW) begin
      scan_end_addr_reg[7:0] <= w_data_reg[7:0];
    end
  end
end

// ----------------------------------------------------------------
// axi4-lite read path
// ----------------------------------------------------------------
assign o_arready = !o_rvalid;

always @* begin
  rd_hit = 1'b1;
  case ({i_araddr[7:2], 2'h0})
    `NSC_OFF_SHIFT_HIGH: rd_byte = crc_shift[15:8];
    `NSC_OFF_SHIFT_LOW: rd_byte = crc_shift[7:0];
    `NSC_OFF_TAPS_HIGH: rd_byte = taps_reg[15:8];
    `NSC_OFF_TAPS_LOW: rd_byte = {taps_reg[7:1], 1'b1};
    `NSC_OFF_SCAN_CTRL: rd_byte = {scan_en_reg, scan_run_reg, busy,
                                   invalid, irq_suspend_mode_reg, 1'b0,
                                   access_mode_bits_reg};
    `NSC_OFF_CUR_HIGH: rd_byte = scan_current_addr_reg[15:8];
    `NSC_OFF_CUR_LOW: rd_byte = scan_current_addr_reg[7:0];
    `NSC_OFF_END_HIGH: rd_byte = scan_end_addr_reg[15:8];
    `NSC_OFF_END_LOW: rd_byte = scan_end_addr_reg[7:0];
    `NSC_OFF_TRIG_SEL: rd_byte = {4'h0, trigger_select_reg};
    `NSC_OFF_CRC_CFG: rd_byte = {crc_en_reg, 3'h0, poly_length_reg};
    default: begin
      rd_byte = `NSC_RST_BYTE;
      rd_hit = 1'b0;
    end
  endcase
end

always @(posedge i_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    o_rvalid <= 1'b0;
    o_rdata <= 32'h0000_0000;
    o_rresp <= 2'h0;
  end else if (i_arvalid && !o_rvalid) begin
    o_rvalid <= 1'b1;
    o_rdata <= {24'h00_0000, rd_byte};
    o_rresp <= rd_hit ? 2'h0 : 2'h2;
  end else if (o_rvalid && i_rready) begin
    o_rvalid <= 1'b0;
  end
end

endmodule // nsc_scanner

`default_nettype wire
